// ---- bst_defines.vh ----
// constants of the boundary-scan test port
`ifndef BST_DEFINES_VH
`define BST_DEFINES_VH

// ****************************************
// instruction register
// ****************************************
`define BST_IR_W 3
`define BST_IR_CAPTURE 3'h5
`define BST_OP_EXTEST 3'h0
`define BST_OP_SAMPLE 3'h1
`define BST_OP_IDCODE 3'h2
`define BST_OP_TESTMODE 3'h3
`define BST_OP_HIGHZ 3'h4
`define BST_OP_CLAMP 3'h6

// ****************************************
// data register selection codes
// ****************************************
`define BST_SEL_CHAIN 2'h0
`define BST_SEL_ID 2'h1
`define BST_SEL_TM 2'h2
`define BST_SEL_BYPASS 2'h3

// ****************************************
// data register sizes and test mode reset value
// ****************************************
`define BST_ID_W 32
`define BST_TM_W 8
`define BST_TM_RESET 8'h00

// ****************************************
// boundary chain layout, bit 0 next to the serial output
// ****************************************
`define BST_CHAIN_LEN 38
`define BST_N_IN 12
`define BST_N_OUT 22
`define BST_N_EN 4
`define BST_OUT_LSB 4
`define BST_IN_LSB 26
`define BST_UPD_RESET 26'h0000000

`endif

// ---- bst_boundary_chain.v ----
// boundary chain register: input, output and enable cells
`default_nettype none
`include "bst_defines.vh"

module bst_boundary_chain (
    // clock and reset
    input wire clock,
    input wire rst_sync_n,
    // controls from the tap controller
    input wire do_capture,
    input wire do_shift,
    input wire do_update,
    input wire scan_in,
    // system values
    input wire [`BST_N_IN-1:0] pin_in,
    input wire [`BST_N_OUT-1:0] sys_out,
    input wire [`BST_N_EN-1:0] sys_en,
    // results
    output wire scan_out,
    output wire [`BST_N_OUT-1:0] upd_out,
    output wire [`BST_N_EN-1:0] upd_en
);

    // ****************************************
    // pin input synchroniser
    // ****************************************
    reg [`BST_N_IN-1:0] in_s1;
    reg [`BST_N_IN-1:0] in_s2;
    reg [`BST_N_IN-1:0] in_s3;
    reg [`BST_N_IN-1:0] in_f;
    reg [`BST_CHAIN_LEN-1:0] chain;
    reg [`BST_N_OUT+`BST_N_EN-1:0] upd;

    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            in_s1 <= {`BST_N_IN{1'b0}};
            in_s2 <= {`BST_N_IN{1'b0}};
            in_s3 <= {`BST_N_IN{1'b0}};
            in_f <= {`BST_N_IN{1'b0}};
        end else begin
            in_s1 <= pin_in;
            in_s2 <= in_s1;
            in_s3 <= in_s2;
            in_f <= (in_s2 & in_s3) | (in_f & (in_s2 ^ in_s3));
        end
    end

    // ****************************************
    // capture/shift stages and update flops
    // ****************************************
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            chain <= {`BST_CHAIN_LEN{1'b0}};
            upd <= `BST_UPD_RESET;
        end else begin
            if (do_capture) begin
                chain <= {in_f, sys_out, sys_en};
            end else if (do_shift) begin
                chain <= {scan_in, chain[`BST_CHAIN_LEN-1:1]};
            end
            // input cells have no update flop
            if (do_update) begin
                upd <= chain[`BST_IN_LSB-1:0];
            end
        end
    end

    assign scan_out = chain[0];
    assign upd_out = upd[`BST_N_OUT+`BST_N_EN-1:`BST_OUT_LSB];
    assign upd_en = upd[`BST_N_EN-1:0];

endmodule
`default_nettype wire

// ---- bst_tap.v ----
// boundary-scan test access port: tap controller, instructions, data registers
`default_nettype none
`include "bst_defines.vh"

module bst_tap #(
    // identification fields, values are arbitrary
    parameter [3:0] ID_VERSION = 4'h1,
    parameter [15:0] ID_PART = 16'hA5C3,
    parameter [10:0] ID_MAKER = 11'h2B5
) (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // test port pins
    input wire tck,
    input wire tms,
    input wire tdi,
    // shared test output / line clock pin
    input wire half_rate_line_clock,
    output wire shared_test_out_clock_pin,
    output wire shared_test_out_clock_oe_n,
    // pixel clock pin
    input wire pixel_clock_pin_in,
    output wire pixel_clock_pin_out,
    output wire pixel_clock_pin_oe_n,
    input wire core_pixel_clock,
    input wire core_pixel_clock_en,
    // other pins and their system values
    input wire [`BST_N_IN-2:0] pin_in,
    output wire [`BST_N_OUT-2:0] pin_out,
    input wire [`BST_N_OUT-2:0] core_out,
    output wire [`BST_N_EN-2:0] group_oe_n,
    input wire [`BST_N_EN-2:0] core_group_en,
    // internal test register and status
    output wire [`BST_TM_W-1:0] test_mode,
    output wire test_logic_reset
);

    // ****************************************
    // tap states
    // ****************************************
    localparam [15:0] ST_RESET = 16'h0001;
    localparam [15:0] ST_IDLE = 16'h0002;
    localparam [15:0] ST_SEL_DR = 16'h0004;
    localparam [15:0] ST_CAP_DR = 16'h0008;
    localparam [15:0] ST_SH_DR = 16'h0010;
    localparam [15:0] ST_EX1_DR = 16'h0020;
    localparam [15:0] ST_PA_DR = 16'h0040;
    localparam [15:0] ST_EX2_DR = 16'h0080;
    localparam [15:0] ST_UP_DR = 16'h0100;
    localparam [15:0] ST_SEL_IR = 16'h0200;
    localparam [15:0] ST_CAP_IR = 16'h0400;
    localparam [15:0] ST_SH_IR = 16'h0800;
    localparam [15:0] ST_EX1_IR = 16'h1000;
    localparam [15:0] ST_PA_IR = 16'h2000;
    localparam [15:0] ST_EX2_IR = 16'h4000;
    localparam [15:0] ST_UP_IR = 16'h8000;

    // ****************************************
    // functions
    // ****************************************
    // next tap state from current state and tms
    function [15:0] tap_next;
        input [15:0] st;
        input m;
        begin
            case (st)
                ST_RESET: tap_next = m ? ST_RESET : ST_IDLE;
                ST_IDLE: tap_next = m ? ST_SEL_DR : ST_IDLE;
                ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
                ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
                ST_SH_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
                ST_EX1_DR: tap_next = m ? ST_UP_DR : ST_PA_DR;
                ST_PA_DR: tap_next = m ? ST_EX2_DR : ST_PA_DR;
                ST_EX2_DR: tap_next = m ? ST_UP_DR : ST_SH_DR;
                ST_UP_DR: tap_next = m ? ST_SEL_DR : ST_IDLE;
                ST_SEL_IR: tap_next = m ? ST_RESET : ST_CAP_IR;
                ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
                ST_SH_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
                ST_EX1_IR: tap_next = m ? ST_UP_IR : ST_PA_IR;
                ST_PA_IR: tap_next = m ? ST_EX2_IR : ST_PA_IR;
                ST_EX2_IR: tap_next = m ? ST_UP_IR : ST_SH_IR;
                ST_UP_IR: tap_next = m ? ST_SEL_DR : ST_IDLE;
                default: tap_next = ST_RESET;
            endcase
        end
    endfunction

    // data register picked by an instruction code
    function [1:0] dr_select;
        input [`BST_IR_W-1:0] op;
        begin
            if (op[2]) begin
                dr_select = `BST_SEL_BYPASS;
            end else if (op == `BST_OP_IDCODE) begin
                dr_select = `BST_SEL_ID;
            end else if (op == `BST_OP_TESTMODE) begin
                dr_select = `BST_SEL_TM;
            end else begin
                dr_select = `BST_SEL_CHAIN;
            end
        end
    endfunction

    // ****************************************
    // reset release
    // ****************************************
    reg rst_s1_n;
    reg rst_sync_n;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_s1_n <= 1'b1;
            rst_sync_n <= rst_s1_n;
        end
    end

    // ****************************************
    // test pin sampling: {tck, tms, tdi}
    // ****************************************
    reg [2:0] tp_s1;
    reg [2:0] tp_s2;
    reg [2:0] tp_s3;
    reg [2:0] tp_f;
    wire [2:0] next_tp_f;
    wire tck_rise;
    wire tck_fall;
    wire tms_bit;
    wire tdi_bit;

    assign next_tp_f = (tp_s2 & tp_s3) | (tp_f & (tp_s2 ^ tp_s3));
    assign tck_rise = next_tp_f[2] & ~tp_f[2];
    assign tck_fall = ~next_tp_f[2] & tp_f[2];
    assign tms_bit = next_tp_f[1];
    assign tdi_bit = next_tp_f[0];

    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tp_s1 <= 3'h0;
            tp_s2 <= 3'h0;
            tp_s3 <= 3'h0;
            tp_f <= 3'h0;
        end else begin
            tp_s1 <= {tck, tms, tdi};
            tp_s2 <= tp_s1;
            tp_s3 <= tp_s2;
            tp_f <= next_tp_f;
        end
    end

    // ****************************************
    // tap controller
    // ****************************************
    reg [15:0] state;

    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= ST_RESET;
        end else if (tck_rise) begin
            state <= tap_next(state, tms_bit);
        end
    end

    assign test_logic_reset = (state == ST_RESET);

    // ****************************************
    // instruction register
    // ****************************************
    reg [`BST_IR_W-1:0] ir_shift;
    reg [`BST_IR_W-1:0] ir;
    wire [1:0] sel;
    wire op_extest;
    wire op_clamp;
    wire op_highz;

    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ir_shift <= `BST_IR_CAPTURE;
            ir <= `BST_OP_IDCODE;
        end else begin
            if (tck_rise && state == ST_CAP_IR) begin
                ir_shift <= `BST_IR_CAPTURE;
            end else if (tck_rise && state == ST_SH_IR) begin
                ir_shift <= {tdi_bit, ir_shift[`BST_IR_W-1:1]};
            end
            if (state == ST_RESET) begin
                ir <= `BST_OP_IDCODE;
            end else if (tck_fall && state == ST_UP_IR) begin
                ir <= ir_shift;
            end
        end
    end

    assign sel = dr_select(ir);
    assign op_extest = (ir == `BST_OP_EXTEST);
    assign op_clamp = (ir == `BST_OP_CLAMP);
    assign op_highz = (ir == `BST_OP_HIGHZ);

    // ****************************************
    // bypass, identification and test mode registers
    // ****************************************
    reg bypass;
    reg [`BST_ID_W-1:0] id_shift;
    reg [`BST_TM_W-1:0] tm_shift;
    reg [`BST_TM_W-1:0] tm_reg;
    wire dr_cap;
    wire dr_sh;

    assign dr_cap = tck_rise && (state == ST_CAP_DR);
    assign dr_sh = tck_rise && (state == ST_SH_DR);

    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bypass <= 1'b0;
            id_shift <= {`BST_ID_W{1'b0}};
            tm_shift <= `BST_TM_RESET;
            tm_reg <= `BST_TM_RESET;
        end else begin
            if (dr_cap && sel == `BST_SEL_BYPASS) begin
                bypass <= 1'b0;
            end else if (dr_sh && sel == `BST_SEL_BYPASS) begin
                bypass <= tdi_bit;
            end
            if (dr_cap && sel == `BST_SEL_ID) begin
                id_shift <= {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
            end else if (dr_sh && sel == `BST_SEL_ID) begin
                id_shift <= {tdi_bit, id_shift[`BST_ID_W-1:1]};
            end
            // no capture: the shift stage keeps the last loaded word
            if (dr_sh && sel == `BST_SEL_TM) begin
                tm_shift <= {tdi_bit, tm_shift[`BST_TM_W-1:1]};
            end
            if (tck_fall && state == ST_UP_DR && sel == `BST_SEL_TM) begin
                tm_reg <= tm_shift;
            end
        end
    end

    assign test_mode = tm_reg;

    // ****************************************
    // boundary chain
    // ****************************************
    wire chain_out;
    wire [`BST_N_OUT-1:0] upd_out;
    wire [`BST_N_EN-1:0] upd_en;
    wire chain_sel;

    assign chain_sel = (sel == `BST_SEL_CHAIN);

    bst_boundary_chain u_chain (
        .clock(clock),
        .rst_sync_n(rst_sync_n),
        .do_capture(dr_cap && chain_sel),
        .do_shift(dr_sh && chain_sel),
        .do_update(tck_fall && state == ST_UP_DR && chain_sel),
        .scan_in(tdi_bit),
        .pin_in({pin_in, pixel_clock_pin_in}),
        .sys_out({core_out, core_pixel_clock}),
        .sys_en({core_group_en, core_pixel_clock_en}),
        .scan_out(chain_out),
        .upd_out(upd_out),
        .upd_en(upd_en)
    );

    // ****************************************
    // pin multiplexing
    // ****************************************
    wire use_upd;
    wire [`BST_N_OUT-1:0] drv_out;
    wire [`BST_N_EN-1:0] drv_en;

    assign use_upd = op_extest | op_clamp;
    assign drv_out = use_upd ? upd_out : {core_out, core_pixel_clock};
    assign drv_en = op_highz ? {`BST_N_EN{1'b0}} :
                    (use_upd ? upd_en : {core_group_en, core_pixel_clock_en});

    assign pin_out = drv_out[`BST_N_OUT-1:1];
    assign pixel_clock_pin_out = drv_out[0];
    assign group_oe_n = ~drv_en[`BST_N_EN-1:1];
    assign pixel_clock_pin_oe_n = ~drv_en[0];

    // ****************************************
    // serial output, changed on falling tck
    // ****************************************
    reg tdo_bit;
    reg tdo_drive;
    reg next_tdo_bit;

    always @* begin
        next_tdo_bit = bypass;
        case (sel)
            `BST_SEL_CHAIN: next_tdo_bit = chain_out;
            `BST_SEL_ID: next_tdo_bit = id_shift[0];
            `BST_SEL_TM: next_tdo_bit = tm_shift[0];
            default: next_tdo_bit = bypass;
        endcase
        if (state == ST_SH_IR) begin
            next_tdo_bit = ir_shift[0];
        end
    end

    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tdo_bit <= 1'b0;
            tdo_drive <= 1'b0;
        end else if (tck_fall) begin
            tdo_bit <= next_tdo_bit;
            tdo_drive <= (state == ST_SH_DR) || (state == ST_SH_IR);
        end
    end

    // ****************************************
    // shared pin
    // ****************************************
    assign shared_test_out_clock_pin = test_logic_reset ? half_rate_line_clock : tdo_bit;
    assign shared_test_out_clock_oe_n = test_logic_reset ? 1'b0 : ~tdo_drive;

endmodule
`default_nettype wire

// ---- bst_tap_checker.sv ----
// assertion checker of the boundary-scan test port
`default_nettype none
`include "bst_defines.vh"

module bst_tap_checker (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // test port
    input wire logic tck,
    input wire logic tms,
    input wire logic half_rate_line_clock,
    input wire logic shared_test_out_clock_pin,
    input wire logic shared_test_out_clock_oe_n,
    // pins and system values
    input wire logic pixel_clock_pin_out,
    input wire logic pixel_clock_pin_oe_n,
    input wire logic core_pixel_clock,
    input wire logic core_pixel_clock_en,
    input wire logic [`BST_N_OUT-2:0] pin_out,
    input wire logic [`BST_N_OUT-2:0] core_out,
    input wire logic [`BST_N_EN-2:0] group_oe_n,
    input wire logic [`BST_N_EN-2:0] core_group_en,
    // status
    input wire logic [`BST_TM_W-1:0] test_mode,
    input wire logic test_logic_reset
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // ****
    // a filtered test clock rise seen from the reset state
    // ****
    sequence s_rise_tms_low;
        (test_logic_reset && !tck) [*3] ##1 (tck && !tms) [*6];
    endsequence
    sequence s_rise_tms_high;
        (test_logic_reset && !tck) [*3] ##1 (tck && tms) [*6];
    endsequence

    AST_RESET_STATE: assert property ($rose(rst_n) |->
        test_logic_reset && test_mode == `BST_TM_RESET)
        else $error("reset did not give reset state and cleared test mode");
    AST_SHARED_PIN_TLR: assert property (test_logic_reset |->
        shared_test_out_clock_pin == half_rate_line_clock && !shared_test_out_clock_oe_n)
        else $error("shared pin not carrying line clock in reset state");
    AST_SYSTEM_PATH_TLR: assert property (test_logic_reset &&
        $past(test_logic_reset) |-> pin_out == core_out && group_oe_n == ~core_group_en
        && pixel_clock_pin_out == core_pixel_clock && pixel_clock_pin_oe_n == !core_pixel_clock_en)
        else $error("pins not on system path in reset state");
    AST_TM_HOLD_TLR: assert property (test_logic_reset && $past(test_logic_reset) |->
        $stable(test_mode))
        else $error("test mode changed in reset state");
    AST_STATE_ON_RISE: assert property ($changed(test_logic_reset) |-> tck && $past(tck, 2))
        else $error("state changed away from a test clock rise");
    AST_OE_ON_FALL: assert property (!test_logic_reset && !$past(test_logic_reset)
        && $changed(shared_test_out_clock_oe_n) |-> !tck && !$past(tck, 2))
        else $error("output enable changed away from a test clock fall");
    AST_TDO_STEADY: assert property (!test_logic_reset && !$past(test_logic_reset)
        && tck && $past(tck) |-> $stable(shared_test_out_clock_pin))
        else $error("serial output changed while test clock high");
    AST_LEAVE_TLR: assert property (s_rise_tms_low |-> !test_logic_reset)
        else $error("rise with select low did not leave reset state");
    AST_STAY_TLR: assert property (s_rise_tms_high |-> test_logic_reset)
        else $error("rise with select high left reset state");
endmodule

bind bst_tap bst_tap_checker u_bst_tap_checker (
    .clock(clock), .rst_n(rst_n), .tck(tck), .tms(tms),
    .half_rate_line_clock(half_rate_line_clock),
    .shared_test_out_clock_pin(shared_test_out_clock_pin),
    .shared_test_out_clock_oe_n(shared_test_out_clock_oe_n),
    .pixel_clock_pin_out(pixel_clock_pin_out), .pixel_clock_pin_oe_n(pixel_clock_pin_oe_n),
    .core_pixel_clock(core_pixel_clock), .core_pixel_clock_en(core_pixel_clock_en),
    .pin_out(pin_out), .core_out(core_out), .group_oe_n(group_oe_n),
    .core_group_en(core_group_en), .test_mode(test_mode), .test_logic_reset(test_logic_reset));
`default_nettype wire

// ---- bst_tester.sv ----
// serial tester model driving the four-wire test port
`default_nettype none

module bst_tester (
    // pacing clock
    input wire logic clock,
    // test port
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // one test clock of 16 system clocks: fall, look at the output, rise
    task automatic step(input logic m, input logic d, output logic q, output logic en_n);
        @(posedge clock);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (8) @(posedge clock);
        q = tdo;
        en_n = tdo_oe_n;
        tck <= 1'b1;
        repeat (7) @(posedge clock);
    endtask

    task automatic walk(input logic [7:0] pat, input int n);
        logic q;
        logic e;
        for (int i = 0; i < n; i++) begin
            step(pat[i], 1'b0, q, e);
        end
    endtask

    // shift lsb first, leaving the shift state on the last bit
    task automatic shift(input logic [37:0] din, input int n, output logic [37:0] dout,
                         output logic drv);
        logic e;
        dout = '0;
        drv = 1'b1;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], dout[i], e);
            drv = drv & ~e;
        end
        walk(8'h01, 2);
    endtask

    task automatic dr_scan(input logic [37:0] din, output logic [37:0] dout, output logic drv);
        walk(8'h01, 3);
        shift(din, 38, dout, drv);
    endtask

    task automatic ir_scan(input logic [2:0] op, output logic [2:0] cap);
        logic [37:0] q;
        logic drv;
        walk(8'h03, 4);
        shift({35'h0, op}, 3, q, drv);
        cap = q[2:0];
    endtask
endmodule
`default_nettype wire

// ---- bst_tap_bench.sv ----
// self-checking testbench of the boundary-scan test port
`default_nettype none
`include "bst_defines.vh"
`define BST_CHECK(got, exp) check_val(64'(got), 64'(exp))

module bst_tap_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // identification fields, values are arbitrary
    localparam logic [3:0] ID_VERSION = 4'h3;
    localparam logic [15:0] ID_PART = 16'h5E17;
    localparam logic [10:0] ID_MAKER = 11'h1D3;
    localparam logic [37:0] PRELOAD = 38'h15A5C33C96;
    localparam logic [37:0] PAT = 38'h2C12345679;

    logic clock;
    logic rst_n;
    logic line_clk;
    logic pix_in;
    logic core_pix;
    logic core_pix_en;
    logic [10:0] pin_in;
    logic [20:0] core_out;
    logic [2:0] core_group_en;
    wire tck, tms, tdi, sh_pin, sh_oe_n, pix_out, pix_oe_n, tlr;
    wire [20:0] pin_out;
    wire [2:0] group_oe_n;
    wire [7:0] test_mode;
    wire tdo_line = sh_oe_n ? 1'bz : sh_pin;
    int bad_count = 0;
    int total_checks = 0;

    bst_tap #(.ID_VERSION(ID_VERSION), .ID_PART(ID_PART), .ID_MAKER(ID_MAKER)) u_bst_tap (
        .clock(clock), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
        .half_rate_line_clock(line_clk), .shared_test_out_clock_pin(sh_pin),
        .shared_test_out_clock_oe_n(sh_oe_n), .pixel_clock_pin_in(pix_in),
        .pixel_clock_pin_out(pix_out), .pixel_clock_pin_oe_n(pix_oe_n),
        .core_pixel_clock(core_pix), .core_pixel_clock_en(core_pix_en), .pin_in(pin_in),
        .pin_out(pin_out), .core_out(core_out), .group_oe_n(group_oe_n),
        .core_group_en(core_group_en), .test_mode(test_mode), .test_logic_reset(tlr));

    bst_tester u_bst_tester (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo_line), .tdo_oe_n(sh_oe_n));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) line_clk <= ~line_clk;

    task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic load(input logic [2:0] op);
        logic [2:0] cap;
        u_bst_tester.ir_scan(op, cap);
        `BST_CHECK(cap, `BST_IR_CAPTURE);
    endtask

    task automatic check_tlr();
        `BST_CHECK(tlr, 1'b1);
        repeat (3) begin
            @(negedge clock);
            `BST_CHECK({sh_oe_n, sh_pin}, {1'b0, line_clk});
        end
        `BST_CHECK(pin_out, core_out);
        `BST_CHECK({group_oe_n, pix_oe_n}, {~core_group_en, ~core_pix_en});
    endtask

    task automatic t_idcode();
        logic [37:0] q;
        logic drv;
        `BST_CHECK(test_mode, `BST_TM_RESET);
        u_bst_tester.walk(8'h00, 1);
        `BST_CHECK(tlr, 1'b0);
        u_bst_tester.dr_scan('0, q, drv);
        `BST_CHECK(q[31:0], {ID_VERSION, ID_PART, ID_MAKER, 1'b1});
        `BST_CHECK(drv, 1'b1);
    endtask

    task automatic t_bypass();
        logic [37:0] q;
        logic drv;
        for (int op = 4; op < 8; op++) begin
            load(3'(op));
            u_bst_tester.dr_scan(PAT, q, drv);
            `BST_CHECK(q, {PAT[36:0], 1'b0});
        end
    endtask

    task automatic t_testmode();
        logic [37:0] q;
        logic drv;
        load(`BST_OP_TESTMODE);
        u_bst_tester.dr_scan({8'hA5, 22'h0, PAT[7:0]}, q, drv);
        `BST_CHECK(q[15:0], {PAT[7:0], `BST_TM_RESET});
        `BST_CHECK(test_mode, 8'hA5);
        u_bst_tester.dr_scan({8'h3C, 30'h0}, q, drv);
        `BST_CHECK(q[7:0], 8'hA5);
        `BST_CHECK(test_mode, 8'h3C);
    endtask

    task automatic check_update();
        `BST_CHECK(pin_out, PRELOAD[25:5]);
        `BST_CHECK({group_oe_n, pix_oe_n}, {~PRELOAD[3:1], ~PRELOAD[0]});
        `BST_CHECK(pix_out, PRELOAD[4]);
    endtask

    task automatic t_boundary();
        logic [37:0] q;
        logic drv;
        load(`BST_OP_SAMPLE);
        u_bst_tester.dr_scan(PRELOAD, q, drv);
        `BST_CHECK(q[37:26], {pin_in, pix_in});
        `BST_CHECK(q[25:0], {core_out, core_pix, core_group_en, core_pix_en});
        `BST_CHECK(pin_out, core_out);
        load(`BST_OP_EXTEST);
        check_update();
        load(`BST_OP_CLAMP);
        check_update();
        load(`BST_OP_HIGHZ);
        `BST_CHECK({group_oe_n, pix_oe_n}, 4'hF);
        u_bst_tester.walk(8'h3F, 6);
        check_tlr();
    endtask

    initial begin
        repeat (100000) @(posedge clock);
        bad_count++;
        results();
    end

    initial begin
        rst_n = 1'b0;
        line_clk = 1'b0;
        pix_in = 1'b1;
        core_pix = 1'b0;
        core_pix_en = 1'b1;
        pin_in = 11'h5A3;
        core_out = 21'h0F0F3C;
        core_group_en = 3'h5;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        repeat (8) @(posedge clock);
        check_tlr();
        t_idcode();
        t_bypass();
        t_testmode();
        t_boundary();
        results();
    end
endmodule
`default_nettype wire
